/* flash_boot_pkg.sv */
// Constants, register map and carrier types for the flash boot and emulation control block.
// Assumes an 8-bit register port and a byte-wide flash read port with one cycle of read latency.
package flash_boot_pkg;

    // ============================================================
    // Register map
    localparam logic [23:0] FLASH_CTRL_FIRST_ADDR   = 24'hFFFFC8;
    localparam logic [23:0] FLASH_CTRL_LAST_ADDR    = 24'hFFFFCB;
    localparam logic [23:0] FLASH_WINDOW_REG_ADDR   = 24'hFFFFE0;
    localparam logic [23:0] RAM_OVERLAY_SELECT_ADDR = 24'hFFFFE1;

    // ============================================================
    // Field layouts and reset values
    localparam int          FLASH_WINDOW_BIT        = 3;
    localparam int          OVERLAY_ENABLE_BIT      = 3;
    localparam logic [7:0]  OVERLAY_RW_MASK         = 8'h0F;
    localparam logic [7:0]  OVERLAY_RESET_VALUE     = 8'h00;
    localparam logic [7:0]  FLASH_CTRL_RESET_VALUE  = 8'h00;
    localparam logic [7:0]  READ_ZERO               = 8'h00;
    localparam logic [7:0]  FLASH_ERASED_BYTE       = 8'hFF;
    localparam int          FLASH_CTRL_COUNT        = 4;

    // ============================================================
    // Memory map constants
    localparam logic [23:0] RAM_PROGRAM_START       = 24'hFF8400;
    localparam logic [23:0] RAM_PROGRAM_END         = 24'hFFFBFF;
    localparam int          FLASH_ADDR_WIDTH        = 18;
    localparam logic [17:0] PROM_LAST_ADDR          = 18'h3FFFF;
    localparam int          FLASH_BYTES_DEFAULT     = 262144;

    // ============================================================
    // Timing
    localparam int          BOOT_WAIT_STATES        = 100;
    localparam int          CYCLES_PER_STATE        = 1;
    localparam int          BOOT_WAIT_CYCLES        = BOOT_WAIT_STATES * CYCLES_PER_STATE;
    localparam int          LOW_PERIOD_BITS         = 9;
    localparam int          LOW_COUNT_WIDTH         = 16;
    localparam int          BIT_RATE_WIDTH          = 8;

    typedef enum logic [3:0] {
        ST_USER,
        ST_PROM,
        ST_BOOT_WAIT,
        ST_BOOT_IDLE_HIGH,
        ST_BOOT_MEASURE,
        ST_BOOT_DIVIDE,
        ST_BOOT_BLANK_CHECK,
        ST_BOOT_ERASE,
        ST_BOOT_LOAD,
        ST_BOOT_HANDOFF,
        ST_BOOT_DONE
    } boot_state_e;

    typedef struct packed {
        logic [FLASH_CTRL_COUNT-1:0][7:0] regs;
    } flash_ctrl_s;

    typedef struct packed {
        logic       receive_enable_bit;
        logic       transmit_enable_bit;
        logic [7:0] bit_rate_reg;
    } serial_ctrl_s;

    typedef struct packed {
        logic       port3_bit1_direction;
        logic       port3_bit1_output_value;
    } port3_bit1_s;

endpackage

/* low_period_timer.sv */
// Times one low pulse on an already synchronised serial receive level.
// Assumes the caller arms it only while the line is idle high.
`timescale 1ns/1ps

module low_period_timer
    import flash_boot_pkg::*;
#(
    parameter int COUNT_WIDTH = LOW_COUNT_WIDTH
)
(
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   clk_en_in,
    input  wire logic                   arm_in,
    input  wire logic                   rx_level_in,
    output logic                        done_out,
    output logic [COUNT_WIDTH-1:0]      low_count_out
);

    initial
    begin
        if (COUNT_WIDTH < 4 || COUNT_WIDTH > 32)
            $error("low_period_timer: COUNT_WIDTH out of range");
    end

    typedef struct packed {
        logic                   running;
        logic                   done;
        logic [COUNT_WIDTH-1:0] count;
    } timer_s;

    timer_s state;
    timer_s next_state;

    // ============================================================
    // Next state
    always_comb
    begin
        next_state      = state;
        next_state.done = 1'b0;
        if (!arm_in)
        begin
            next_state.running = 1'b0;
            next_state.count   = '0;
        end
        else if (!state.running && !rx_level_in)
        begin
            next_state.running = 1'b1;
            next_state.count   = COUNT_WIDTH'(1);
        end
        else if (state.running && !rx_level_in)
        begin
            // Saturate rather than wrap on a stuck-low line
            if (state.count != '1)
                next_state.count = state.count + COUNT_WIDTH'(1);
        end
        else if (state.running)
        begin
            next_state.running = 1'b0;
            next_state.done    = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state <= '0;
        else if (clk_en_in)
            state <= next_state;
    end

    assign done_out      = state.done;
    assign low_count_out = state.count;

endmodule

/* flash_boot_ctrl.sv */
// Flash boot-mode sequencer, PROM address path, flash register window and RAM overlay select.
// Assumes mode straps and the receive pin come from pins; bus, flash and SCI signals share ref_clk_in.
//
// Overview of operation
// - Coming out of reset in boot mode the block times the low period on the serial one receive pin.
// - About 100 states pass after boot reset before low-period timing may start.
// - In boot mode any flash byte other than all ones causes every flash block to be erased.
// - Before jumping to the RAM program area the serial one enables are cleared, keeping the bit rate.
// - At hand-off the serial one transmit pin is a port output driving high.
// - In PROM mode the 256-kbyte ROM maps programmer addresses 0 to 3FFFF onto the same flash bytes.
// - With the window enable set, FFFFC8 to FFFFCB reach the flash control registers, else they hold.
// - The flash window enable bit resets to zero.
// - Reserved bits beside the window enable and the overlay register top nibble read zero, ignore writes.
// - The overlay register holds an enable bit and a three-bit area field in its low bits.
// - The overlay register clears on reset and hardware standby and holds through software standby.
`timescale 1ns/1ps

module flash_boot_ctrl
    import flash_boot_pkg::*;
#(
    parameter int FLASH_BYTES = FLASH_BYTES_DEFAULT,
    parameter int WAIT_CYCLES = BOOT_WAIT_CYCLES
)
(
    input  wire logic                        ref_clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic                        clk_en_in,
    input  wire logic                        boot_mode_in,
    input  wire logic                        prom_mode_in,
    input  wire logic                        user_program_mode_in,
    input  wire logic                        hw_standby_in,
    input  wire logic                        sw_standby_in,
    // Register port
    input  wire logic [23:0]                 reg_addr_in,
    input  wire logic [7:0]                  reg_wdata_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    output logic [7:0]                       reg_rdata_out,
    // Serial channel one pins and SCI
    input  wire logic                        serial1_receive_pin_in,
    input  wire logic                        sci_txd_in,
    output logic                             serial1_transmit_pin_out,
    output logic                             serial1_transmit_pin_oe_out,
    output serial_ctrl_s                     serial_ctrl_out,
    output port3_bit1_s                      port3_bit1_out,
    // Flash array
    output logic                             flash_rd_out,
    output logic [FLASH_ADDR_WIDTH-1:0]      flash_addr_out,
    input  wire logic [7:0]                  flash_rdata_in,
    output logic                             flash_erase_all_out,
    input  wire logic                        flash_erase_done_in,
    output flash_ctrl_s                      flash_ctrl_out,
    // PROM programmer side
    input  wire logic [FLASH_ADDR_WIDTH-1:0] prom_addr_in,
    input  wire logic                        prom_rd_in,
    output logic [7:0]                       prom_rdata_out,
    // Boot program and overlay
    input  wire logic                        boot_load_done_in,
    output logic                             jump_to_ram_out,
    output logic [23:0]                      jump_addr_out,
    output logic                             boot_busy_out,
    output logic                             overlay_enable_bit_out,
    output logic [2:0]                       overlay_area_out,
    output logic                             overlay_unsettled_out
);

    localparam int WAIT_WIDTH = $clog2(WAIT_CYCLES + 1);

    initial
    begin
        if (FLASH_BYTES < 2 || FLASH_BYTES > (1 << FLASH_ADDR_WIDTH))
            $error("flash_boot_ctrl: FLASH_BYTES out of range");
        if (WAIT_CYCLES < 2 || WAIT_CYCLES > 65535)
            $error("flash_boot_ctrl: WAIT_CYCLES out of range");
    end

    localparam logic [FLASH_ADDR_WIDTH-1:0] FLASH_LAST = FLASH_ADDR_WIDTH'(FLASH_BYTES - 1);
    localparam logic [WAIT_WIDTH-1:0]       WAIT_LAST  = WAIT_WIDTH'(WAIT_CYCLES - 1);
    localparam logic [LOW_COUNT_WIDTH-1:0]  LOW_BITS   = LOW_COUNT_WIDTH'(LOW_PERIOD_BITS);

    // ============================================================
    // Reset release
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    assign rst_n = rst_sync[1];

    // ============================================================
    // State
    typedef struct packed {
        logic [1:0]                   rx_sync;
        logic [1:0]                   boot_sync;
        logic [1:0]                   prom_sync;
        logic                         straps_taken;
        boot_state_e                  fsm;
        logic [WAIT_WIDTH-1:0]        wait_count;
        logic [LOW_COUNT_WIDTH-1:0]   remainder;
        logic [BIT_RATE_WIDTH-1:0]    quotient;
        logic [FLASH_ADDR_WIDTH-1:0]  scan_addr;
        logic                         scan_pending;
        logic                         scan_last;
        logic                         flash_dirty;
        logic                         window_enable;
        logic [7:0]                   overlay;
        logic                         overlay_unsettled;
        logic [FLASH_CTRL_COUNT-1:0][7:0] flash_ctrl;
        serial_ctrl_s                 serial;
        port3_bit1_s                  port3;
        logic                         jump;
        logic [7:0]                   rdata;
        logic [7:0]                   prom_rdata;
        logic                         prom_pending;
    } ctrl_s;

    ctrl_s state;
    ctrl_s next_state;

    logic                       timer_done;
    logic [LOW_COUNT_WIDTH-1:0] timer_count;
    logic                       timer_arm;
    logic                       rx_level;

    assign rx_level  = state.rx_sync[1];
    assign timer_arm = (state.fsm == ST_BOOT_MEASURE);

    low_period_timer #(
        .COUNT_WIDTH   (LOW_COUNT_WIDTH)
    ) u_low_period_timer (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n),
        .clk_en_in     (clk_en_in),
        .arm_in        (timer_arm),
        .rx_level_in   (rx_level),
        .done_out      (timer_done),
        .low_count_out (timer_count)
    );

    function automatic logic in_flash_window(input logic [23:0] addr);
        in_flash_window = (addr >= FLASH_CTRL_FIRST_ADDR) && (addr <= FLASH_CTRL_LAST_ADDR);
    endfunction

    function automatic logic [1:0] flash_ctrl_index(input logic [23:0] addr);
        flash_ctrl_index = 2'(addr - FLASH_CTRL_FIRST_ADDR);
    endfunction

    // ============================================================
    // Next state
    always_comb
    begin
        next_state                   = state;
        next_state.rx_sync           = {state.rx_sync[0], serial1_receive_pin_in};
        next_state.boot_sync         = {state.boot_sync[0], boot_mode_in};
        next_state.prom_sync         = {state.prom_sync[0], prom_mode_in};
        next_state.jump              = 1'b0;
        next_state.scan_pending      = 1'b0;
        next_state.prom_pending      = 1'b0;
        next_state.overlay_unsettled = 1'b0;
        next_state.rdata             = READ_ZERO;

        // Straps settle through their synchronisers before being acted on
        if (!state.straps_taken)
        begin
            next_state.straps_taken = state.wait_count[1];
            next_state.wait_count   = state.wait_count + WAIT_WIDTH'(1);
            if (next_state.straps_taken)
            begin
                next_state.wait_count = '0;
                if (state.prom_sync[1])
                    next_state.fsm = ST_PROM;
                else if (state.boot_sync[1])
                    next_state.fsm = ST_BOOT_WAIT;
                else
                    next_state.fsm = ST_USER;
            end
        end
        else
        begin
            case (state.fsm)
                ST_BOOT_WAIT:
                begin
                    if (state.wait_count == WAIT_LAST)
                        next_state.fsm = ST_BOOT_IDLE_HIGH;
                    else
                        next_state.wait_count = state.wait_count + WAIT_WIDTH'(1);
                end
                ST_BOOT_IDLE_HIGH:
                begin
                    // A line still low here would be mistimed, so wait for idle
                    if (rx_level)
                        next_state.fsm = ST_BOOT_MEASURE;
                end
                ST_BOOT_MEASURE:
                begin
                    if (timer_done)
                    begin
                        next_state.remainder = timer_count;
                        next_state.quotient  = '0;
                        next_state.fsm       = ST_BOOT_DIVIDE;
                    end
                end
                ST_BOOT_DIVIDE:
                begin
                    // Low pulse spans start bit plus eight zero bits
                    if (state.remainder >= LOW_BITS && state.quotient != '1)
                    begin
                        next_state.remainder = state.remainder - LOW_BITS;
                        next_state.quotient  = state.quotient + BIT_RATE_WIDTH'(1);
                    end
                    else
                    begin
                        next_state.serial.bit_rate_reg        = state.quotient;
                        next_state.serial.receive_enable_bit  = 1'b1;
                        next_state.serial.transmit_enable_bit = 1'b1;
                        next_state.scan_addr                  = '0;
                        next_state.scan_last                  = 1'b0;
                        next_state.flash_dirty                = 1'b0;
                        next_state.scan_pending               = 1'b0;
                        next_state.fsm                        = ST_BOOT_BLANK_CHECK;
                    end
                end
                ST_BOOT_BLANK_CHECK:
                begin
                    if (state.scan_pending)
                    begin
                        if (flash_rdata_in != FLASH_ERASED_BYTE)
                            next_state.fsm = ST_BOOT_ERASE;
                        else if (state.scan_addr == FLASH_LAST)
                            next_state.fsm = ST_BOOT_LOAD;
                        else
                        begin
                            next_state.scan_addr    = state.scan_addr + FLASH_ADDR_WIDTH'(1);
                        end
                    end
                    else
                        next_state.scan_pending = 1'b1;
                end
                ST_BOOT_ERASE:
                begin
                    next_state.flash_dirty = 1'b1;
                    if (flash_erase_done_in)
                        next_state.fsm = ST_BOOT_LOAD;
                end
                ST_BOOT_LOAD:
                begin
                    if (boot_load_done_in)
                        next_state.fsm = ST_BOOT_HANDOFF;
                end
                ST_BOOT_HANDOFF:
                begin
                    // Bit rate is left as detected for the RAM program to reuse
                    next_state.serial.receive_enable_bit  = 1'b0;
                    next_state.serial.transmit_enable_bit = 1'b0;
                    next_state.port3.port3_bit1_direction    = 1'b1;
                    next_state.port3.port3_bit1_output_value = 1'b1;
                    next_state.jump = 1'b1;
                    next_state.fsm  = ST_BOOT_DONE;
                end
                default:
                begin
                    next_state.fsm = state.fsm;
                end
            endcase
        end

        // PROM mode: programmer address equals flash byte address
        if (state.fsm == ST_PROM && prom_rd_in && prom_addr_in <= PROM_LAST_ADDR)
            next_state.prom_pending = 1'b1;
        if (state.prom_pending)
            next_state.prom_rdata = flash_rdata_in;

        // Register writes
        if (reg_wr_in)
        begin
            if (reg_addr_in == FLASH_WINDOW_REG_ADDR)
                next_state.window_enable = reg_wdata_in[FLASH_WINDOW_BIT];
            else if (reg_addr_in == RAM_OVERLAY_SELECT_ADDR)
            begin
                next_state.overlay           = reg_wdata_in & OVERLAY_RW_MASK;
                next_state.overlay_unsettled = 1'b1;
            end
            else if (in_flash_window(reg_addr_in) && state.window_enable)
                next_state.flash_ctrl[flash_ctrl_index(reg_addr_in)] = reg_wdata_in;
        end

        // Register reads, answered next cycle
        if (reg_rd_in)
        begin
            if (reg_addr_in == FLASH_WINDOW_REG_ADDR)
                next_state.rdata = 8'(state.window_enable) << FLASH_WINDOW_BIT;
            else if (reg_addr_in == RAM_OVERLAY_SELECT_ADDR)
                next_state.rdata = state.overlay & OVERLAY_RW_MASK;
            else if (in_flash_window(reg_addr_in) && state.window_enable)
                next_state.rdata = state.flash_ctrl[flash_ctrl_index(reg_addr_in)];
        end

        // Software standby keeps the overlay; only hardware standby clears it
        if (hw_standby_in)
        begin
            next_state.overlay           = OVERLAY_RESET_VALUE;
            next_state.overlay_unsettled = 1'b0;
        end
        if (sw_standby_in && !hw_standby_in)
            next_state.overlay = next_state.overlay;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state               <= '0;
            state.fsm           <= ST_USER;
            state.overlay       <= OVERLAY_RESET_VALUE;
            state.window_enable <= 1'b0;
            state.flash_ctrl    <= {FLASH_CTRL_COUNT{FLASH_CTRL_RESET_VALUE}};
        end
        else if (clk_en_in)
            state <= next_state;
    end

    // ============================================================
    // Outputs
    logic boot_scanning;

    assign boot_scanning = (state.fsm == ST_BOOT_BLANK_CHECK) && !state.scan_pending;

    assign reg_rdata_out          = state.rdata;
    assign serial_ctrl_out        = state.serial;
    assign port3_bit1_out         = state.port3;
    assign flash_ctrl_out.regs    = state.flash_ctrl;
    assign prom_rdata_out         = state.prom_rdata;
    assign jump_to_ram_out        = state.jump;
    assign jump_addr_out          = RAM_PROGRAM_START;
    assign flash_erase_all_out    = (state.fsm == ST_BOOT_ERASE);
    assign overlay_enable_bit_out = state.overlay[OVERLAY_ENABLE_BIT];
    assign overlay_area_out       = state.overlay[2:0];
    assign overlay_unsettled_out  = state.overlay_unsettled;
    assign boot_busy_out          = state.straps_taken && state.fsm != ST_USER && state.fsm != ST_PROM
                                    && state.fsm != ST_BOOT_DONE;

    always_comb
    begin
        flash_rd_out   = 1'b0;
        flash_addr_out = state.scan_addr;
        if (state.fsm == ST_PROM)
        begin
            flash_rd_out   = prom_rd_in && prom_addr_in <= PROM_LAST_ADDR;
            flash_addr_out = prom_addr_in;
        end
        else if (boot_scanning)
            flash_rd_out = 1'b1;
    end

    // SCI owns the pin while transmitting; else the port bit drives it
    always_comb
    begin
        if (state.serial.transmit_enable_bit)
        begin
            serial1_transmit_pin_out    = sci_txd_in;
            serial1_transmit_pin_oe_out = 1'b1;
        end
        else
        begin
            serial1_transmit_pin_out    = state.port3.port3_bit1_output_value;
            serial1_transmit_pin_oe_out = state.port3.port3_bit1_direction;
        end
    end

endmodule

/* flash_boot_ctrl_chk.sv */
// Assertions on the register port, overlay register and boot hand-off.
// Assumes one clock domain; bound onto flash_boot_ctrl below.
`timescale 1ns/1ps
module flash_boot_ctrl_chk import flash_boot_pkg::*;
(
    input wire logic         ref_clk_in, rst_n_in, hw_standby_in, reg_wr_in, reg_rd_in, jump_to_ram_out,
    input wire logic [23:0]  reg_addr_in,
    input wire logic [7:0]   reg_wdata_in, reg_rdata_out,
    input wire logic         overlay_enable_bit_out,
    input wire logic [2:0]   overlay_area_out,
    input wire serial_ctrl_s serial_ctrl_out,
    input wire port3_bit1_s  port3_bit1_out
);
    wire [7:0] ovl    = {4'h0, overlay_enable_bit_out, overlay_area_out};
    wire       ovl_rd = reg_rd_in && reg_addr_in == RAM_OVERLAY_SELECT_ADDR;
    wire       win_rd = reg_rd_in && reg_addr_in == FLASH_WINDOW_REG_ADDR;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence ovl_wr_s; reg_wr_in && reg_addr_in == RAM_OVERLAY_SELECT_ADDR && !hw_standby_in; endsequence
    rd_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    ovl_wr_a: assert property (ovl_wr_s |=> ovl == ($past(reg_wdata_in) & 8'h0F))
        else $error("overlay write lost");
    ovl_rd_a: assert property (ovl_rd |=> reg_rdata_out == $past(ovl))
        else $error("overlay read wrong");
    win_rsvd_a: assert property (win_rd |=> (reg_rdata_out & 8'hF7) == 8'h00)
        else $error("window reserved bits set");
    stby_clear_a: assert property (hw_standby_in |=> ovl == 8'h00)
        else $error("overlay kept in standby");
    jump_once_a: assert property (jump_to_ram_out |=> !jump_to_ram_out)
        else $error("jump pulse too long");
    sci_stop_a: assert property (jump_to_ram_out |-> !serial_ctrl_out[9:8] && $stable(serial_ctrl_out.bit_rate_reg))
        else $error("serial not stopped at jump");
    txd_high_a: assert property (jump_to_ram_out |-> (port3_bit1_out == 2'b11) [*4])
        else $error("transmit pin not high output");
endmodule
bind flash_boot_ctrl flash_boot_ctrl_chk chk (.ref_clk_in, .rst_n_in, .hw_standby_in, .reg_wr_in, .reg_rd_in,
    .jump_to_ram_out, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .overlay_enable_bit_out, .overlay_area_out,
    .serial_ctrl_out, .port3_bit1_out);

/* host_programmer_model.sv */
// Host programmer on the serial one receive line.
// Assumes the bench calls send_low once the boot wait is over.
`timescale 1ns/1ps
module host_programmer_model
(
    input  wire logic ref_clk_in,
    output logic      rx_out
);
    // Pulled-up line, high across reset release
    initial rx_out = 1'b1;
    task automatic send_low(input int cycles);
        @(posedge ref_clk_in) rx_out <= 1'b0;
        repeat (cycles) @(posedge ref_clk_in);
        rx_out <= 1'b1;
    endtask
endmodule

/* flash_boot_ctrl_tb_top.sv */
// Bench: registers, PROM read path, boot hand-off.
// Assumes a 16-byte flash model answering one cycle after each read.
`timescale 1ns/1ps
module flash_boot_ctrl_tb_top import flash_boot_pkg::*;;
    logic ref_clk_in = 0, rst_n_in = 0, clk_en_in = 1, boot_mode_in = 0, prom_mode_in = 0, user_program_mode_in = 0;
    logic hw_standby_in = 0, sw_standby_in = 0, reg_wr_in = 0, reg_rd_in = 0, sci_txd_in = 0, flash_erase_done_in = 0;
    logic prom_rd_in = 0, boot_load_done_in = 0, serial1_receive_pin_in, jump_to_ram_out, flash_erase_all_out;
    logic [23:0]  reg_addr_in = 0, jump_addr_out;
    logic [17:0]  prom_addr_in = 0, flash_addr_out;
    logic [7:0]   reg_wdata_in = 0, flash_rdata_in = 0, reg_rdata_out, prom_rdata_out, mem [16];
    serial_ctrl_s serial_ctrl_out;
    port3_bit1_s  port3_bit1_out;
    int           n_fail = 0, checks = 0, cyc = 0, ecnt = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    flash_boot_ctrl #(.FLASH_BYTES(16)) dut (.ref_clk_in, .rst_n_in, .clk_en_in, .boot_mode_in, .prom_mode_in,
        .user_program_mode_in, .hw_standby_in, .sw_standby_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .serial1_receive_pin_in, .sci_txd_in, .serial1_transmit_pin_out(),
        .serial1_transmit_pin_oe_out(), .serial_ctrl_out, .port3_bit1_out, .flash_rd_out(), .flash_addr_out,
        .flash_rdata_in, .flash_erase_all_out, .flash_erase_done_in, .flash_ctrl_out(), .prom_addr_in, .prom_rd_in,
        .prom_rdata_out, .boot_load_done_in, .jump_to_ram_out, .jump_addr_out, .boot_busy_out(),
        .overlay_enable_bit_out(), .overlay_area_out(), .overlay_unsettled_out());
    host_programmer_model host (.ref_clk_in, .rx_out(serial1_receive_pin_in));
    // Flash array answers a cycle late; erase completes after a few cycles
    always @(posedge ref_clk_in)
    begin
        flash_rdata_in <= mem[flash_addr_out[3:0]];
        ecnt <= flash_erase_all_out ? ecnt + 1 : 0;
        flash_erase_done_in <= ecnt == 4;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            summarize;
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Write when w is set, else read and compare against d
    task automatic bus(input logic w, input logic [23:0] a, input logic [7:0] d);
        @(posedge ref_clk_in) {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} <= {w, !w, a, d};
        @(posedge ref_clk_in) {reg_wr_in, reg_rd_in} <= 2'b00;
        @(negedge ref_clk_in) if (!w) chk("reg_rdata_out", reg_rdata_out, d);
    endtask
    task automatic rst(input logic b, p);
        @(posedge ref_clk_in) {rst_n_in, boot_mode_in, prom_mode_in} <= {1'b0, b, p};
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
    endtask
    task automatic t_regs;
        bus(0, 24'hFFFFE0, 8'h00);
        bus(1, 24'hFFFFC9, 8'h5A);
        bus(1, 24'hFFFFE0, 8'hFF);
        bus(0, 24'hFFFFC9, 8'h00);
        bus(0, 24'hFFFFE0, 8'h08);
        bus(1, 24'hFFFFC9, 8'hA5);
        bus(1, 24'hFFFFE0, 8'h00);
        bus(0, 24'hFFFFC9, 8'h00);
        bus(1, 24'hFFFFE0, 8'h08);
        bus(0, 24'hFFFFC9, 8'hA5);
        bus(0, 24'hFFFFE1, 8'h00);
        bus(1, 24'hFFFFE1, 8'hFF);
        @(posedge ref_clk_in) sw_standby_in <= 1'b1;
        bus(0, 24'hFFFFE1, 8'h0F);
        @(posedge ref_clk_in) hw_standby_in <= 1'b1;
        bus(0, 24'hFFFFE1, 8'h00);
    endtask
    task automatic t_prom;
        @(posedge ref_clk_in) {prom_addr_in, prom_rd_in} <= {18'h3FFFF, 1'b1};
        @(negedge ref_clk_in) chk("flash_addr_out", flash_addr_out, 18'h3FFFF);
        @(posedge ref_clk_in) prom_rd_in <= 1'b0;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in) chk("prom_rdata_out", prom_rdata_out, 8'h3C);
    endtask
    task automatic t_boot;
        repeat (120) @(posedge ref_clk_in);
        host.send_low(31);
        repeat (60) if (!serial_ctrl_out.receive_enable_bit) @(negedge ref_clk_in);
        chk("serial_ctrl_out", serial_ctrl_out, 10'h303);
        repeat (200) if (!flash_erase_all_out) @(negedge ref_clk_in);
        chk("flash_erase_all_out", flash_erase_all_out, 1'b1);
        @(posedge ref_clk_in) boot_load_done_in <= 1'b1;
        repeat (60) if (!jump_to_ram_out) @(negedge ref_clk_in);
        chk("jump_addr_out", {jump_to_ram_out, jump_addr_out}, {1'b1, 24'hFF8400});
        chk("serial_ctrl_out", serial_ctrl_out, 10'h003);
    endtask
    task automatic summarize;
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hFF;
        mem[15] = 8'h3C;
        rst(0, 0);
        t_regs;
        rst(0, 1);
        t_prom;
        rst(1, 0);
        t_boot;
        summarize;
    end
endmodule
